// ===== hw/snd_pkg.sv
// Purpose: constants and types shared by the serial nonvolatile memory command decoder
// Assumes: sampled serial link, system clock much faster than the serial clock
// Notes: all opcodes, field positions and counts live here
package snd_pkg;
	localparam logic [7:0] OPC_SET_LATCH = 8'h06;
	localparam logic [7:0] OPC_CLEAR_LATCH = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
	localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;
	localparam logic [7:0] OPC_FAST_ARRAY_READ = 8'h0B;
	localparam logic [7:0] OPC_IDENTITY_READ = 8'h9F;
	localparam logic [7:0] OPC_UNIQUE_ID_READ = 8'h4C;
	localparam logic [7:0] OPC_SERIAL_WRITE = 8'hC2;
	localparam logic [7:0] OPC_SERIAL_READ = 8'hC3;
	localparam logic [7:0] OPC_SECTOR_WRITE = 8'h42;
	localparam logic [7:0] OPC_SECTOR_READ = 8'h4B;
	localparam logic [7:0] OPC_FAST_SECTOR_READ = 8'h49;

	localparam int ARR_AW = 19;
	localparam int SEC_AW = 8;
	localparam logic [5:0] OPC_LAST_BIT = 6'h07;
	localparam logic [5:0] ADDR_LAST_BIT = 6'h17;
	localparam logic [5:0] DUMMY_LAST_BIT = 6'h07;
	localparam logic [5:0] SERIAL_LAST_BIT = 6'h3F;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [3:0] ID_BYTES = 4'h4;
	localparam logic [3:0] LONG_ID_BYTES = 4'h8;
	localparam logic [SEC_AW-1:0] SEC_TOP = 8'hFF;
	localparam logic [ARR_AW-1:0] ARR_TOP = 19'h7_FFFF;
	localparam logic [ARR_AW-1:0] PROT_QUARTER_BASE = 19'h6_0000;
	localparam logic [ARR_AW-1:0] PROT_HALF_BASE = 19'h4_0000;

	// status layout: [7] lock, [6:4] spare, [3:2] block protect, [1] latch, [0] zero
	localparam int ST_LOCK_BIT = 7;
	localparam int ST_NV_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_BP_LO = 2;
	localparam logic [5:0] ST_NV_RESET = 6'h00;

	// synchroniser lanes
	localparam int SYN_W = 4;
	localparam int LN_CS = 0;
	localparam int LN_SCK = 1;
	localparam int LN_SI = 2;
	localparam int LN_WP = 3;
	localparam logic [SYN_W-1:0] SYN_RESET = 4'h9;

	typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_IDLE} snd_state_e;
endpackage : snd_pkg

// ===== hw/snd_sync.sv
// Purpose: two-stage synchroniser with edge detection for the serial pins
// Assumes: pins are asynchronous to clk_sys and much slower
// Notes: edges are taken between stage two and a third register only
`timescale 1ns/1ps
`default_nettype none
module snd_sync import snd_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [SYN_W-1:0] pin_in,
	output logic [SYN_W-1:0] lvl,
	output logic [SYN_W-1:0] rise,
	output logic [SYN_W-1:0] fall
);
	logic [SYN_W-1:0] stg1_r;
	logic [SYN_W-1:0] stg2_r;
	logic [SYN_W-1:0] stg3_r;

	genvar g;
	generate
		for (g = 0; g < SYN_W; g++) begin : g_lane
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					stg1_r[g] <= SYN_RESET[g];
					stg2_r[g] <= SYN_RESET[g];
					stg3_r[g] <= SYN_RESET[g];
				end else begin
					stg1_r[g] <= pin_in[g];
					stg2_r[g] <= stg1_r[g];
					stg3_r[g] <= stg2_r[g];
				end
			end
			assign lvl[g] = stg2_r[g];
			assign rise[g] = stg2_r[g] & ~stg3_r[g];
			assign fall[g] = ~stg2_r[g] & stg3_r[g];
		end
	endgenerate
endmodule : snd_sync
`default_nettype wire

// ===== hw/snd_top.sv
// Purpose: op-code decoder and sequencer for a serial nonvolatile byte memory
// Assumes: serial clock at most a sixth of clk_sys; array is an external sync ram
// Notes: mem_rdata is expected one cycle after mem_addr changes
`timescale 1ns/1ps
`default_nettype none
module snd_top import snd_pkg::*; #(
	parameter logic [31:0] DEV_ID = 32'h5A01_7F23, // arbitrary value
	parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic wp_n,
	output logic so,
	output logic so_oe,
	output logic [ARR_AW-1:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	input wire logic [7:0] mem_rdata,
	output logic write_enable_latch,
	output logic [7:0] status_byte
);
	logic [SYN_W-1:0] lvl;
	logic [SYN_W-1:0] rise;
	logic [SYN_W-1:0] fall;
	logic cs_s;
	logic si_s;
	logic wp_s;
	logic rx;
	logic tx;

	snd_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in({wp_n, si, sck, cs_n}),
		.lvl(lvl),
		.rise(rise),
		.fall(fall)
	);

	assign cs_s = lvl[LN_CS];
	assign si_s = lvl[LN_SI];
	assign wp_s = lvl[LN_WP];
	// edges while deselected are dropped here, nothing below sees them
	assign rx = rise[LN_SCK] & ~cs_s;
	assign tx = fall[LN_SCK] & ~cs_s;

	function automatic logic is_read(input logic [7:0] c);
		is_read = (c == OPC_STATUS_READ) || (c == OPC_ARRAY_READ) ||
			(c == OPC_FAST_ARRAY_READ) || (c == OPC_IDENTITY_READ) ||
			(c == OPC_UNIQUE_ID_READ) || (c == OPC_SERIAL_READ) ||
			(c == OPC_SECTOR_READ) || (c == OPC_FAST_SECTOR_READ);
	endfunction : is_read

	function automatic logic is_protected(input logic [ARR_AW-1:0] a, input logic [1:0] bp);
		unique case (bp)
			2'b00: is_protected = 1'b0;
			2'b01: is_protected = (a >= PROT_QUARTER_BASE);
			2'b10: is_protected = (a >= PROT_HALF_BASE);
			2'b11: is_protected = 1'b1;
		endcase
	endfunction : is_protected

	snd_state_e state_r;
	logic [5:0] cnt_r;
	logic [7:0] cmd_r;
	logic [7:0] sh_r;
	logic [23:0] addr_sh_r;
	logic wel_r;
	logic [5:0] stat_nv_r;
	logic [ARR_AW-1:0] arr_addr_r;
	logic [SEC_AW-1:0] sec_addr_r;
	logic sec_end_r;
	logic [3:0] idx_r;
	logic [7:0] tx_sh_r;
	logic [2:0] tx_cnt_r;
	logic [63:0] sn_sh_r;
	logic [63:0] sn_r;
	logic sn_written_r;
	logic [7:0] sector_mem [0:(1<<SEC_AW)-1];

	logic [7:0] rx_byte;
	logic [23:0] addr_full;
	logic [1:0] bp;
	logic [7:0] status_now;
	logic opc_done;
	logic addr_done;
	logic data_byte;
	logic arr_wr_step;
	logic arr_wr_go;
	logic sec_wr_go;
	logic stat_wr_go;
	logic sn_wr_go;
	logic tx_hold;
	logic tx_load;
	logic tx_shift;
	logic [7:0] tx_byte;
	logic [31:0] id_shift;
	logic [63:0] uid_shift;
	logic [63:0] sn_shift;

	function automatic logic is_read_arr();
		is_read_arr = (cmd_r == OPC_ARRAY_READ) || (cmd_r == OPC_FAST_ARRAY_READ);
	endfunction : is_read_arr

	assign rx_byte = {sh_r[6:0], si_s};
	assign addr_full = {addr_sh_r[22:0], si_s};
	assign bp = stat_nv_r[ST_BP_HI-ST_NV_LO:ST_BP_LO-ST_NV_LO];
	assign status_now = {stat_nv_r, wel_r, 1'b0};
	assign opc_done = rx && (state_r == ST_OPC) && (cnt_r == OPC_LAST_BIT);
	assign addr_done = rx && (state_r == ST_ADDR) && (cnt_r == ADDR_LAST_BIT);
	assign data_byte = rx && (state_r == ST_DATA) && (cnt_r[2:0] == BYTE_LAST_BIT);
	assign arr_wr_step = data_byte && (cmd_r == OPC_ARRAY_WRITE);
	// refused bytes still advance the address so later bytes land where expected
	assign arr_wr_go = arr_wr_step && wel_r &&
		!is_protected(arr_addr_r, bp);
	assign sec_wr_go = data_byte && (cmd_r == OPC_SECTOR_WRITE) &&
		wel_r && !sec_end_r;
	assign stat_wr_go = data_byte && (cmd_r == OPC_STATUS_WRITE) && wel_r &&
		!(stat_nv_r[ST_LOCK_BIT-ST_NV_LO] && !wp_s);
	assign sn_wr_go = rx && (state_r == ST_DATA) && (cmd_r == OPC_SERIAL_WRITE) &&
		(cnt_r == SERIAL_LAST_BIT) && wel_r && !sn_written_r;

	assign id_shift = DEV_ID << {idx_r, 3'b000};
	assign uid_shift = UNIQUE_ID << {idx_r, 3'b000};
	assign sn_shift = sn_r << {idx_r, 3'b000};

	always_comb begin
		tx_byte = 8'h00;
		tx_hold = 1'b0;
		unique case (cmd_r)
			OPC_STATUS_READ: tx_byte = status_now;
			OPC_ARRAY_READ, OPC_FAST_ARRAY_READ: tx_byte = mem_rdata;
			OPC_SECTOR_READ, OPC_FAST_SECTOR_READ: begin
				tx_byte = sector_mem[sec_addr_r];
				tx_hold = sec_end_r;
			end
			OPC_IDENTITY_READ: begin
				tx_byte = id_shift[31:24];
				tx_hold = (idx_r >= ID_BYTES);
			end
			OPC_UNIQUE_ID_READ: begin
				tx_byte = uid_shift[63:56];
				tx_hold = (idx_r >= LONG_ID_BYTES);
			end
			OPC_SERIAL_READ: begin
				tx_byte = sn_shift[63:56];
				tx_hold = (idx_r >= LONG_ID_BYTES);
			end
			default: tx_hold = 1'b1;
		endcase
	end

	assign tx_load = tx && (state_r == ST_DATA) && is_read(cmd_r) && (tx_cnt_r == 3'h0) && !tx_hold;
	assign tx_shift = tx && (state_r == ST_DATA) && is_read(cmd_r) && (tx_cnt_r != 3'h0);

	// phase sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_n || cs_s) begin
			state_r <= ST_OPC;
			cnt_r <= 6'h00;
			cmd_r <= 8'h00;
			sh_r <= 8'h00;
			addr_sh_r <= 24'h00_0000;
		end else if (rx) begin
			sh_r <= rx_byte;
			cnt_r <= cnt_r + 6'h01;
			unique case (state_r)
				ST_OPC: begin
					if (opc_done) begin
						cmd_r <= rx_byte;
						cnt_r <= 6'h00;
						unique case (rx_byte)
							OPC_STATUS_READ, OPC_STATUS_WRITE, OPC_IDENTITY_READ,
							OPC_UNIQUE_ID_READ, OPC_SERIAL_READ, OPC_SERIAL_WRITE:
								state_r <= ST_DATA;
							OPC_ARRAY_READ, OPC_ARRAY_WRITE, OPC_FAST_ARRAY_READ,
							OPC_SECTOR_READ, OPC_SECTOR_WRITE, OPC_FAST_SECTOR_READ:
								state_r <= ST_ADDR;
							// latch commands and unknown codes take no further bits
							default: state_r <= ST_IDLE;
						endcase
					end
				end
				ST_ADDR: begin
					addr_sh_r <= addr_full;
					if (addr_done) begin
						cnt_r <= 6'h00;
						if (cmd_r == OPC_FAST_ARRAY_READ || cmd_r == OPC_FAST_SECTOR_READ) begin
							state_r <= ST_DUMMY;
						end else begin
							state_r <= ST_DATA;
						end
					end
				end
				ST_DUMMY: begin
					if (cnt_r == DUMMY_LAST_BIT) begin
						cnt_r <= 6'h00;
						state_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (cmd_r == OPC_STATUS_WRITE && cnt_r[2:0] == BYTE_LAST_BIT) begin
						state_r <= ST_IDLE;
					end else if (cmd_r == OPC_SERIAL_WRITE && cnt_r == SERIAL_LAST_BIT) begin
						state_r <= ST_IDLE;
					// serial write counts all 64 bits, no restart per byte
					end else if (cmd_r != OPC_SERIAL_WRITE && cnt_r[2:0] == BYTE_LAST_BIT) begin
						cnt_r <= 6'h00;
					end
				end
				ST_IDLE: cnt_r <= 6'h00;
			endcase
		end
	end

	// latch and nonvolatile status bits
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wel_r <= 1'b0;
			stat_nv_r <= ST_NV_RESET;
		end else begin
			if (opc_done && rx_byte == OPC_SET_LATCH) begin
				wel_r <= 1'b1;
			end else if (opc_done && rx_byte == OPC_CLEAR_LATCH) begin
				wel_r <= 1'b0;
			end
			if (stat_wr_go) begin
				stat_nv_r <= rx_byte[7:2];
			end
		end
	end

	// address pointers, output shifter
	always_ff @(posedge clk_sys) begin
		if (!rst_n || cs_s) begin
			arr_addr_r <= '0;
			sec_addr_r <= '0;
			sec_end_r <= 1'b0;
			idx_r <= 4'h0;
			tx_sh_r <= 8'h00;
			tx_cnt_r <= 3'h0;
		end else begin
			if (addr_done) begin
				arr_addr_r <= addr_full[ARR_AW-1:0];
				sec_addr_r <= addr_full[SEC_AW-1:0];
				sec_end_r <= 1'b0;
			end
			if (arr_wr_step) begin
				arr_addr_r <= arr_addr_r + 19'h0_0001;
			end
			if (sec_wr_go || (tx_load && !is_read_arr())) begin
				if (cmd_r == OPC_SECTOR_WRITE || cmd_r == OPC_SECTOR_READ ||
					cmd_r == OPC_FAST_SECTOR_READ) begin
					if (sec_addr_r == SEC_TOP) begin
						sec_end_r <= 1'b1;
					end else begin
						sec_addr_r <= sec_addr_r + 8'h01;
					end
				end
			end
			if (tx_load) begin
				tx_sh_r <= {tx_byte[6:0], 1'b0};
				tx_cnt_r <= 3'h1;
				if (is_read_arr()) begin
					arr_addr_r <= arr_addr_r + 19'h0_0001;
				end
				if (cmd_r != OPC_STATUS_READ) begin
					idx_r <= idx_r + 4'h1;
				end
			end else if (tx_shift) begin
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
				tx_cnt_r <= tx_cnt_r + 3'h1;
			end
		end
	end

	// serial output pin
	always_ff @(posedge clk_sys) begin
		if (!rst_n || cs_s) begin
			so <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			so_oe <= (state_r == ST_DATA) && is_read(cmd_r);
			if (tx_load) begin
				so <= tx_byte[7];
			end else if (tx_shift) begin
				so <= tx_sh_r[7];
			end
		end
	end

	// array port, address lags one cycle so a write sees its own address
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mem_addr <= '0;
			mem_wdata <= 8'h00;
			mem_we <= 1'b0;
		end else begin
			mem_addr <= arr_addr_r;
			mem_we <= arr_wr_go;
			if (arr_wr_go) begin
				mem_wdata <= rx_byte;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sec_wr_go) begin
			sector_mem[sec_addr_r] <= rx_byte;
		end
	end

	// serial number, one time only
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sn_sh_r <= 64'h0000_0000_0000_0000;
			sn_r <= 64'h0000_0000_0000_0000;
			sn_written_r <= 1'b0;
		end else begin
			if (rx && state_r == ST_DATA && cmd_r == OPC_SERIAL_WRITE) begin
				sn_sh_r <= {sn_sh_r[62:0], si_s};
			end
			if (sn_wr_go) begin
				sn_r <= {sn_sh_r[62:0], si_s};
				sn_written_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			write_enable_latch <= 1'b0;
			status_byte <= 8'h00;
		end else begin
			write_enable_latch <= wel_r;
			status_byte <= status_now;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_set_latch;
		opc_done && rx_byte == OPC_SET_LATCH;
	endsequence
	sequence s_clear_latch;
		opc_done && rx_byte == OPC_CLEAR_LATCH;
	endsequence
	sequence s_arr_top_load;
		tx_load && is_read_arr() && arr_addr_r == ARR_TOP;
	endsequence

	set_latch_a: assert property (s_set_latch |=> wel_r ##1 write_enable_latch)
		else $error("latch not set");
	clear_latch_a: assert property (s_clear_latch |=> !wel_r ##1 !write_enable_latch)
		else $error("latch not cleared");
	deselect_idle_a: assert property (cs_s |=>
		state_r == ST_OPC && !so_oe && cnt_r == 6'h00)
		else $error("deselect did not idle");
	protected_write_a: assert property (mem_we |-> wel_r && !is_protected(mem_addr, bp))
		else $error("write into protected range");
	status_bits_a: assert property (status_byte[0] == 1'b0 &&
		status_byte[1] == $past(wel_r))
		else $error("status low bits wrong");
	serial_once_a: assert property (sn_written_r |=> sn_written_r && $stable(sn_r))
		else $error("serial number rewritten");
	output_edge_a: assert property ($changed(so) |-> $past(fall[LN_SCK]) || $past(cs_s))
		else $error("output moved off falling edge");
	read_wrap_a: assert property (s_arr_top_load |=> arr_addr_r == '0)
		else $error("array read did not wrap");
	sector_stop_a: assert property (sec_end_r && !cs_s |=>
		sec_end_r || $past(addr_done))
		else $error("sector address wrapped");
	partial_opc_a: assert property (state_r == ST_OPC && cnt_r != OPC_LAST_BIT |=>
		$stable(wel_r))
		else $error("partial op-code acted");
endmodule : snd_top
`default_nettype wire

// ===== sim/snd_host.sv
// Purpose: behavioural serial host that frames commands for the decoder
// Assumes: mode 0, sck idles low and stands still between frames
// Notes: read bits are taken just before the next fall, where so still stands
`timescale 1ns/1ps
`default_nettype none
module snd_host (
	input wire logic clk_sys,
	input wire logic so,
	input wire logic so_oe,
	output logic sck,
	output logic cs_n,
	output logic si,
	output logic rd_valid,
	output logic [63:0] rd_data
);
	initial begin
		sck = 1'h0;
		cs_n = 1'h1;
		si = 1'h0;
		rd_valid = 1'h0;
		rd_data = 64'h0000_0000_0000_0000;
	end

	// half of a 400 ns serial period
	task automatic hp;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : hp

	// only defined op-codes, or the leading bits of one, are handed in by the bench
	task automatic frame(input logic [95:0] tx, input int ntx, input int nrx);
		logic [63:0] rx;
		rx = 64'h0000_0000_0000_0000;
		cs_n = 1'h0;
		hp();
		for (int i = 0; i < ntx + nrx; i++) begin
			sck = 1'h0;
			// input ignored in read phase, so keep it moving
			si = (i < ntx) ? tx[ntx-1-i] : ~si;
			hp();
			sck = 1'h1;
			hp();
			// an undriven line must never read as a good bit
			if (i >= ntx) rx = {rx[62:0], so_oe ? so : 1'hx};
		end
		sck = 1'h0;
		hp();
		cs_n = 1'h1;
		si = ~si;
		if (nrx > 0) begin
			rd_data = rx;
			rd_valid = 1'h1;
			@(posedge clk_sys);
			#1;
			rd_valid = 1'h0;
		end
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : frame
endmodule : snd_host
`default_nettype wire

// ===== sim/test_spi_nvram_command_decoder.sv
// Purpose: self-checking bench for the serial memory command decoder
// Assumes: external array modelled as a one-cycle synchronous ram
// Notes: reads and array writes are checked from queues by one watcher process
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module test_spi_nvram_command_decoder import snd_pkg::*;;
	localparam logic [31:0] DEV_ID_T = 32'h3C5A_0F96; // arbitrary value
	localparam logic [63:0] UID_T = 64'hD00D_1234_5678_9ABC; // arbitrary value
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic wp_n = 1'h1;
	logic sck, cs_n, si, so, so_oe, mem_we, write_enable_latch, rd_valid;
	logic [18:0] mem_addr;
	logic [7:0] mem_wdata, status_byte, d0, d1, s0, s1, s2, s3;
	logic [7:0] mem_rdata = 8'h00;
	logic [63:0] rd_data, sn, exp_r;
	logic [26:0] exp_w;
	logic [7:0] ram [0:524287];
	logic [18:0] pa [3] = '{19'h3_FFFF, 19'h5_FFFF, 19'h6_0000};
	logic [63:0] exp_rd [$];
	logic [26:0] exp_wr [$];
	int failures = 0;
	int tests_run = 0;

	always #25 clk_sys = ~clk_sys;

	snd_top #(.DEV_ID(DEV_ID_T), .UNIQUE_ID(UID_T)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
		.write_enable_latch(write_enable_latch), .status_byte(status_byte));
	snd_host u_host (.clk_sys(clk_sys), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
		.si(si), .rd_valid(rd_valid), .rd_data(rd_data));

	always @(posedge clk_sys) begin
		mem_rdata <= ram[mem_addr];
		if (mem_we === 1'h1) ram[mem_addr] <= mem_wdata;
	end

	// an unexpected strobe meets an unknown note and fails
	always @(posedge clk_sys) begin
		if (mem_we === 1'h1) begin
			exp_w = exp_wr.size() ? exp_wr.pop_front() : 27'hx;
			`CHK({mem_addr, mem_wdata}, exp_w)
		end
		if (rd_valid === 1'h1) begin
			exp_r = exp_rd.size() ? exp_rd.pop_front() : 64'hx;
			`CHK(rd_data, exp_r)
		end
	end

	function automatic logic prot(input logic [1:0] bp, input logic [18:0] a);
		return bp == 2'h3 || (bp == 2'h2 && a >= 19'h4_0000) || (bp == 2'h1 && a >= 19'h6_0000);
	endfunction : prot

	task automatic run(input logic [95:0] tx, input int ntx, input int nrx, input logic [63:0] e);
		if (nrx > 0) exp_rd.push_back(e);
		u_host.frame(tx, ntx, nrx);
	endtask : run

	task automatic wr(input logic [23:0] a, input logic [7:0] d, input logic ok);
		if (ok) exp_wr.push_back({a[18:0], d});
		run({OPC_ARRAY_WRITE, a, d}, 40, 0, 64'h0);
	endtask : wr

	task automatic sw(input logic [7:0] v);
		run({OPC_STATUS_WRITE, v}, 16, 0, 64'h0);
	endtask : sw

	task automatic end_of_test;
		if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (90000) @(posedge clk_sys);
		failures++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h0000_0fa4));
		repeat (8) @(posedge clk_sys);
		#1 rst_n = 1'h1;
		repeat (8) @(posedge clk_sys);
		#1;
		{d0, d1, s0, s1} = $urandom;
		{s2, s3} = 16'($urandom);
		sn = {$urandom, $urandom};
		`CHK(status_byte, 8'h00)
		`CHK(write_enable_latch, 1'h0)
		run(OPC_SET_LATCH[7:4], 4, 0, 64'h0);
		`CHK(write_enable_latch, 1'h0)
		wr(24'h00_0010, d0, 1'h0);
		run(OPC_SET_LATCH, 8, 0, 64'h0);
		`CHK(write_enable_latch, 1'h1)
		exp_wr.push_back({19'h7_FFFF, d0});
		exp_wr.push_back({19'h0_0000, d1});
		run({OPC_ARRAY_WRITE, 24'hFF_FFFF, d0, d1}, 48, 0, 64'h0);
		`CHK(write_enable_latch, 1'h1)
		run({OPC_ARRAY_READ, 24'hE7_FFFF}, 32, 16, {d0, d1});
		run({OPC_FAST_ARRAY_READ, 24'h07_FFFF, 8'hA5}, 40, 8, d0);
		`CHK(so_oe, 1'h0)
		for (int bp = 0; bp < 4; bp++) begin
			sw({4'h0, bp[1:0], 2'h0});
			`CHK(status_byte, {4'h0, bp[1:0], 2'h2})
			foreach (pa[k]) wr({5'h1F, pa[k]}, d1, !prot(bp[1:0], pa[k]));
		end
		sw(8'hFF);
		`CHK(status_byte, 8'hFE)
		run(OPC_STATUS_READ, 8, 16, 64'hFEFE);
		wp_n = 1'h0;
		sw(8'h00);
		`CHK(status_byte, 8'hFE)
		wp_n = 1'h1;
		sw(8'h00);
		`CHK(status_byte, 8'h02)
		run(OPC_IDENTITY_READ, 8, 40, {DEV_ID_T, {8{DEV_ID_T[0]}}});
		run(OPC_UNIQUE_ID_READ, 8, 64, UID_T);
		run(OPC_SERIAL_READ, 8, 64, 64'h0);
		run({OPC_SERIAL_WRITE, sn}, 72, 0, 64'h0);
		run({OPC_SERIAL_WRITE, ~sn}, 72, 0, 64'h0);
		run(OPC_SERIAL_READ, 8, 64, sn);
		run({OPC_SECTOR_WRITE, 24'h00_0000, s3}, 40, 0, 64'h0);
		run({OPC_SECTOR_WRITE, 24'hAB_CDFE, s0, s1, s2}, 56, 0, 64'h0);
		run({OPC_SECTOR_READ, 24'h12_34FE}, 32, 16, {s0, s1});
		run({OPC_FAST_SECTOR_READ, 24'h00_00FF, 8'h3C}, 40, 8, s1);
		run({OPC_SECTOR_READ, 24'h00_0000}, 32, 8, s3);
		run(OPC_CLEAR_LATCH, 8, 0, 64'h0);
		`CHK(write_enable_latch, 1'h0)
		sw(8'h0C);
		`CHK(status_byte, 8'h00)
		repeat (20) @(posedge clk_sys);
		`CHK(exp_rd.size(), 0)
		`CHK(exp_wr.size(), 0)
		end_of_test();
	end
endmodule : test_spi_nvram_command_decoder
`default_nettype wire
